// ---- src/bsf_pkg.sv ----
package bsf_pkg;

    // data path and memory sizes
    localparam int DATA_W       = 8;
    localparam int RF_DEPTH     = 32;
    localparam int IO_DEPTH     = 8;
    localparam int STACK_DEPTH  = 16;

    // wishbone byte addresses
    localparam logic [7:0] ADR_CMD    = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_SP     = 8'h08;
    localparam logic [7:0] ADR_STATE  = 8'h0C;

    // command word field positions
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_BIT_LSB = 5;
    localparam int CMD_REG_LSB = 8;
    localparam int CMD_IO_LSB  = 13;

    // status_register flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // values after reset
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] SP_RESET     = 8'h0F;

    // execution lengths in clock cycles
    localparam logic [1:0] CYC_SINGLE = 2'h1;
    localparam logic [1:0] CYC_DOUBLE = 2'h2;

    typedef enum logic [4:0] {
        OP_NO_OPERATION,
        OP_STACK_PUSH,
        OP_STACK_POP,
        OP_IO_BIT_SET_INSTR,
        OP_IO_BIT_CLEAR_INSTR,
        OP_LOGICAL_LEFT_SHIFT,
        OP_LOGICAL_RIGHT_SHIFT,
        OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY,
        OP_ARITH_RIGHT_SHIFT,
        OP_NIBBLE_SWAP,
        OP_BIT_TO_TRANSFER_FLAG,
        OP_TRANSFER_FLAG_TO_BIT,
        OP_CARRY_FLAG_SET,
        OP_CARRY_FLAG_CLEAR,
        OP_NEGATIVE_FLAG_SET,
        OP_NEGATIVE_FLAG_CLEAR,
        OP_ZERO_FLAG_SET,
        OP_ZERO_FLAG_CLEAR,
        OP_OVERFLOW_FLAG_SET,
        OP_OVERFLOW_FLAG_CLEAR,
        OP_SIGN_FLAG_SET,
        OP_SIGN_FLAG_CLEAR,
        OP_TRANSFER_FLAG_SET,
        OP_TRANSFER_FLAG_CLEAR,
        OP_IRQ_ENABLE,
        OP_IRQ_DISABLE,
        OP_SLEEP_INSTR,
        OP_WATCHDOG_RESTART_INSTR
    } bsf_op_e;

    typedef enum {ST_IDLE, ST_EXEC} bsf_state_e;

    // stack and i/o bit operations take two cycles, all else one
    function automatic logic [1:0] op_cycles(input bsf_op_e op);
        return (op inside {OP_STACK_PUSH, OP_STACK_POP, OP_IO_BIT_SET_INSTR,
                           OP_IO_BIT_CLEAR_INSTR}) ? CYC_DOUBLE : CYC_SINGLE;
    endfunction

    function automatic logic op_is_shift(input bsf_op_e op);
        return op inside {OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT,
                          OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
                          OP_ARITH_RIGHT_SHIFT};
    endfunction

    // register file window 0x80..0xFC, i/o window 0x40..0x5C
    function automatic logic adr_is_rf(input logic [7:0] adr);
        return adr[7] && (adr[1:0] == 2'h0);
    endfunction

    function automatic logic adr_is_io(input logic [7:0] adr);
        return (adr[7:5] == 3'h2) && (adr[1:0] == 2'h0);
    endfunction

endpackage

// ---- src/bsf_shift_unit.sv ----
`timescale 1ns/100ps
module bsf_shift_unit (
    input  wire logic             i_op_is_swap,
    input  wire bsf_pkg::bsf_op_e i_op,
    input  wire logic [7:0]       i_value,
    input  wire logic             i_carry,
    output logic      [7:0]       o_result,
    output logic                  o_c,
    output logic                  o_z,
    output logic                  o_n,
    output logic                  o_v
);
    import bsf_pkg::*;

    // result and carry per shift kind; flags derive from the result
    always_comb begin
        o_result = i_value;
        o_c      = i_carry;
        unique case (i_op)
            OP_LOGICAL_LEFT_SHIFT: begin
                o_result = {i_value[6:0], 1'b0};
                o_c      = i_value[7];
            end
            OP_LOGICAL_RIGHT_SHIFT: begin
                o_result = {1'b0, i_value[7:1]};
                o_c      = i_value[0];
            end
            OP_ROTATE_LEFT_CARRY: begin
                o_result = {i_value[6:0], i_carry};
                o_c      = i_value[7];
            end
            OP_ROTATE_RIGHT_CARRY: begin
                o_result = {i_carry, i_value[7:1]};
                o_c      = i_value[0];
            end
            OP_ARITH_RIGHT_SHIFT: begin
                o_result = {i_value[7], i_value[7:1]};  // sign stays
                o_c      = i_value[0];
            end
            default: begin
                if (i_op_is_swap) begin
                    o_result = {i_value[3:0], i_value[7:4]};
                end
            end
        endcase
        o_n = o_result[7];
        o_z = (o_result == 8'h00);
        o_v = o_n ^ o_c;  // n xor c after any shift
    end

endmodule

// ---- src/bsf_regfile.sv ----
`timescale 1ns/100ps
module bsf_regfile #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_rst,
    input  wire logic [$clog2(DEPTH)-1:0] i_rd_a_idx,
    output logic      [WIDTH-1:0]         o_rd_a_data,
    input  wire logic [$clog2(DEPTH)-1:0] i_rd_b_idx,
    output logic      [WIDTH-1:0]         o_rd_b_data,
    input  wire logic                     i_wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] i_wr_idx,
    input  wire logic [WIDTH-1:0]         i_wr_data
);
    logic [WIDTH-1:0] mem_reg [DEPTH];

    // cleared at reset so the first shift sees a known value
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else if (i_wr_en) begin
            mem_reg[i_wr_idx] <= i_wr_data;
        end
    end

    // two combinational read ports: execution and bus
    assign o_rd_a_data = mem_reg[i_rd_a_idx];
    assign o_rd_b_data = mem_reg[i_rd_b_idx];

endmodule

// ---- src/bsf_exec.sv ----
// Notes on behaviour
// - push stores register, two cycles, flags kept
// - pop loads register, two cycles, flags kept
// - i/o bit set, two cycles, rest kept
// - i/o bit clear, two cycles, rest kept
// - left shift, zero in, zcnv, one cycle
// - right shift, zero in, zcnv, one cycle
// - rotate left via carry, zcnv, one cycle
// - rotate right via carry, zcnv, one cycle
// - arithmetic right shift keeps sign, one cycle
// - register bit to transfer flag only
// - transfer flag to register bit, no flags
// - overflow flag set or clear only
// - sign flag set, one cycle, others kept
// - sign flag clear, others kept
// - sleep: one cycle, flags kept, request out
// - watchdog restart: one cycle, pulse out
//
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
module bsf_exec #(
    parameter int STACK_DEPTH = bsf_pkg::STACK_DEPTH
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    output logic             o_busy,
    output logic             o_sleep_req,
    output logic             o_wdt_restart
);
    import bsf_pkg::*;

    localparam int SW = $clog2(STACK_DEPTH);

    bsf_state_e  state_reg;
    logic [1:0]  cnt_reg;
    bsf_op_e     op_reg;
    logic [2:0]  bit_reg;
    logic [4:0]  rd_reg;
    logic [2:0]  io_reg;
    logic [7:0]  status_reg;
    logic [7:0]  status_next;
    logic [7:0]  sp_reg;
    logic [7:0]  io_bank [IO_DEPTH];
    logic [7:0]  stack_mem [STACK_DEPTH];
    logic        ack_reg;
    logic [31:0] dat_reg;
    logic        sleep_reg;
    logic        wdt_reg;

    logic        bus_take;
    logic        bus_wr;
    logic        idle;
    logic        cmd_take;
    bsf_op_e     cmd_op_in;
    logic        done;
    logic [7:0]  rf_a;
    logic [7:0]  rf_b;
    logic        rf_wr_en;
    logic [4:0]  rf_wr_idx;
    logic [7:0]  rf_wr_data;
    logic        exec_rf_wr;
    logic [7:0]  sh_result;
    logic        sh_c;
    logic        sh_z;
    logic        sh_n;
    logic        sh_v;
    logic [SW-1:0] pop_idx;
    logic [7:0]  bld_value;

    // request decode; one access per ack, ack drops the cycle after
    assign bus_take  = i_wb_cyc && i_wb_stb && !ack_reg;
    assign bus_wr    = bus_take && i_wb_we;
    assign idle      = (state_reg == ST_IDLE);
    assign cmd_op_in = bsf_op_e'(i_wb_dat[CMD_OP_LSB +: 5]);
    // a command written while busy is dropped, not queued
    assign cmd_take  = bus_wr && idle && (i_wb_adr == ADR_CMD) && (i_wb_sel[1:0] == 2'h3);
    assign done      = (state_reg == ST_EXEC) && (cnt_reg == 2'h0);
    assign o_busy    = !idle;
    assign o_wb_ack  = ack_reg;
    assign o_wb_dat  = dat_reg;
    assign o_sleep_req   = sleep_reg;
    assign o_wdt_restart = wdt_reg;
    assign pop_idx   = SW'(sp_reg + 8'h01);
    assign bld_value = rf_a & ~(8'h01 << bit_reg) | ({7'h00, status_reg[FLAG_T]} << bit_reg);

    bsf_regfile #(
        .WIDTH (DATA_W),
        .DEPTH (RF_DEPTH)
    ) u_regfile (
        .i_ref_clk   (i_ref_clk),
        .i_rst       (i_rst),
        .i_rd_a_idx  (rd_reg),
        .o_rd_a_data (rf_a),
        .i_rd_b_idx  (i_wb_adr[6:2]),
        .o_rd_b_data (rf_b),
        .i_wr_en     (rf_wr_en),
        .i_wr_idx    (rf_wr_idx),
        .i_wr_data   (rf_wr_data)
    );

    bsf_shift_unit u_shift (
        .i_op_is_swap (op_reg == OP_NIBBLE_SWAP),
        .i_op         (op_reg),
        .i_value      (rf_a),
        .i_carry      (status_reg[FLAG_C]),
        .o_result     (sh_result),
        .o_c          (sh_c),
        .o_z          (sh_z),
        .o_n          (sh_n),
        .o_v          (sh_v)
    );

    // bus ack and read data, registered
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= bus_take;
            if (bus_take && !i_wb_we) begin
                if (adr_is_rf(i_wb_adr)) begin
                    dat_reg <= {24'h00_0000, rf_b};
                end else if (adr_is_io(i_wb_adr)) begin
                    dat_reg <= {24'h00_0000, io_bank[i_wb_adr[4:2]]};
                end else begin
                    unique case (i_wb_adr)
                        ADR_CMD:    dat_reg <= {16'h0000, io_reg, rd_reg, bit_reg, op_reg};
                        ADR_STATUS: dat_reg <= {24'h00_0000, status_reg};
                        ADR_SP:     dat_reg <= {24'h00_0000, sp_reg};
                        ADR_STATE:  dat_reg <= {31'h0000_0000, o_busy};
                        default:    dat_reg <= 32'h0000_0000;  // unmapped reads zero
                    endcase
                end
            end
        end
    end

    // command capture and cycle counting
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 2'h0;
            op_reg    <= OP_NO_OPERATION;
            bit_reg   <= 3'h0;
            rd_reg    <= 5'h00;
            io_reg    <= 3'h0;
        end else if (cmd_take) begin
            state_reg <= ST_EXEC;
            cnt_reg   <= op_cycles(cmd_op_in) - 2'h1;
            op_reg    <= cmd_op_in;
            bit_reg   <= i_wb_dat[CMD_BIT_LSB +: 3];
            rd_reg    <= i_wb_dat[CMD_REG_LSB +: 5];
            io_reg    <= i_wb_dat[CMD_IO_LSB +: 3];
        end else if (done) begin
            state_reg <= ST_IDLE;
        end else if (!idle) begin
            cnt_reg <= cnt_reg - 2'h1;
        end
    end

    // register file write: execution result or bus when idle
    always_comb begin
        exec_rf_wr = done && (op_is_shift(op_reg) || op_reg inside
                     {OP_NIBBLE_SWAP, OP_TRANSFER_FLAG_TO_BIT, OP_STACK_POP});
        rf_wr_en   = exec_rf_wr || (bus_wr && idle && adr_is_rf(i_wb_adr) && i_wb_sel[0]);
        rf_wr_idx  = exec_rf_wr ? rd_reg : i_wb_adr[6:2];
        rf_wr_data = i_wb_dat[7:0];
        if (exec_rf_wr) begin
            if (op_reg == OP_STACK_POP) begin
                rf_wr_data = stack_mem[pop_idx];
            end else if (op_reg == OP_TRANSFER_FLAG_TO_BIT) begin
                rf_wr_data = bld_value;
            end else begin
                rf_wr_data = sh_result;
            end
        end
    end

    // status flags; bus writes only while idle so no overlap with done
    always_comb begin
        status_next = status_reg;
        if (bus_wr && idle && (i_wb_adr == ADR_STATUS) && i_wb_sel[0]) begin
            status_next = i_wb_dat[7:0];
        end else if (done) begin
            if (op_is_shift(op_reg)) begin
                status_next[FLAG_C] = sh_c;
                status_next[FLAG_Z] = sh_z;
                status_next[FLAG_N] = sh_n;
                status_next[FLAG_V] = sh_v;
            end
            unique case (op_reg)
                OP_BIT_TO_TRANSFER_FLAG: status_next[FLAG_T] = rf_a[bit_reg];
                OP_CARRY_FLAG_SET:       status_next[FLAG_C] = 1'b1;
                OP_CARRY_FLAG_CLEAR:     status_next[FLAG_C] = 1'b0;
                OP_NEGATIVE_FLAG_SET:    status_next[FLAG_N] = 1'b1;
                OP_NEGATIVE_FLAG_CLEAR:  status_next[FLAG_N] = 1'b0;
                OP_ZERO_FLAG_SET:        status_next[FLAG_Z] = 1'b1;
                OP_ZERO_FLAG_CLEAR:      status_next[FLAG_Z] = 1'b0;
                OP_OVERFLOW_FLAG_SET:    status_next[FLAG_V] = 1'b1;
                OP_OVERFLOW_FLAG_CLEAR:  status_next[FLAG_V] = 1'b0;
                OP_SIGN_FLAG_SET:        status_next[FLAG_S] = 1'b1;
                OP_SIGN_FLAG_CLEAR:      status_next[FLAG_S] = 1'b0;
                OP_TRANSFER_FLAG_SET:    status_next[FLAG_T] = 1'b1;
                OP_TRANSFER_FLAG_CLEAR:  status_next[FLAG_T] = 1'b0;
                OP_IRQ_ENABLE:           status_next[FLAG_I] = 1'b1;
                OP_IRQ_DISABLE:          status_next[FLAG_I] = 1'b0;
                default: ;  // push, pop, i/o bits, swap, sleep, restart, nop
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            status_reg <= STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // stack pointer: push writes then decrements, pop increments
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sp_reg <= SP_RESET;
        end else if (bus_wr && idle && (i_wb_adr == ADR_SP) && i_wb_sel[0]) begin
            sp_reg <= i_wb_dat[7:0];
        end else if (done && op_reg == OP_STACK_PUSH) begin
            sp_reg <= sp_reg - 8'h01;
        end else if (done && op_reg == OP_STACK_POP) begin
            sp_reg <= sp_reg + 8'h01;
        end
    end

    // stack storage, no reset; wraps inside its depth
    always_ff @(posedge i_ref_clk) begin
        if (done && op_reg == OP_STACK_PUSH) begin
            stack_mem[SW'(sp_reg)] <= rf_a;
        end
    end

    // i/o bank: bus writes whole byte, bit instructions touch one bit
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < IO_DEPTH; i++) begin
                io_bank[i] <= 8'h00;
            end
        end else if (bus_wr && idle && adr_is_io(i_wb_adr) && i_wb_sel[0]) begin
            io_bank[i_wb_adr[4:2]] <= i_wb_dat[7:0];
        end else if (done && op_reg == OP_IO_BIT_SET_INSTR) begin
            io_bank[io_reg][bit_reg] <= 1'b1;
        end else if (done && op_reg == OP_IO_BIT_CLEAR_INSTR) begin
            io_bank[io_reg][bit_reg] <= 1'b0;
        end
    end

    // one-cycle pulses to the sleep and watchdog logic
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sleep_reg <= 1'b0;
            wdt_reg   <= 1'b0;
        end else begin
            sleep_reg <= done && (op_reg == OP_SLEEP_INSTR);
            wdt_reg   <= done && (op_reg == OP_WATCHDOG_RESTART_INSTR);
        end
    end

    push_two_cycles_a: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        cmd_take && cmd_op_in == OP_STACK_PUSH |=> o_busy ##1 o_busy ##1
        (!o_busy && sp_reg == $past(sp_reg, 3) - 8'h01 && status_reg == $past(status_reg, 3)))
        else $error("push did not finish in two cycles");

    pop_two_cycles_a: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        cmd_take && cmd_op_in == OP_STACK_POP |=> o_busy ##1 (o_busy && rf_wr_en) ##1
        (!o_busy && sp_reg == $past(sp_reg, 3) + 8'h01 && status_reg == $past(status_reg, 3)))
        else $error("pop did not finish in two cycles");

    io_bit_set_a: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        done && op_reg == OP_IO_BIT_SET_INSTR |=> io_bank[io_reg][bit_reg] == 1'b1
        && status_reg == $past(status_reg))
        else $error("i/o bit not set");

    io_bit_clear_a: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        done && op_reg == OP_IO_BIT_CLEAR_INSTR |=> io_bank[io_reg][bit_reg] == 1'b0)
        else $error("i/o bit not cleared");

    single_cycle_op_a: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        cmd_take && op_cycles(cmd_op_in) == CYC_SINGLE |=> o_busy ##1 !o_busy)
        else $error("single cycle instruction held busy");

    left_shift_carry_a: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        done && op_reg == OP_LOGICAL_LEFT_SHIFT |=> status_reg[FLAG_C] == $past(rf_a[7])
        && rf_a == {$past(rf_a[6:0]), 1'b0})
        else $error("left shift result or carry wrong");

    rotate_right_carry_a: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        done && op_reg == OP_ROTATE_RIGHT_CARRY |=> status_reg[FLAG_C] == $past(rf_a[0])
        && rf_a[7] == $past(status_reg[FLAG_C]))
        else $error("rotate right through carry wrong");

    bit_store_flag_a: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        done && op_reg == OP_BIT_TO_TRANSFER_FLAG |=> status_reg[FLAG_T] == $past(rf_a[bit_reg])
        && status_reg[5:0] == $past(status_reg[5:0]))
        else $error("transfer flag store wrong");

    overflow_set_a: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        done && op_reg == OP_OVERFLOW_FLAG_SET |=> status_reg == ($past(status_reg) | 8'h08))
        else $error("overflow set touched other flags");

    watchdog_pulse_a: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        cmd_take && cmd_op_in == OP_WATCHDOG_RESTART_INSTR |=>
        ##1 o_wdt_restart ##1 !o_wdt_restart)
        else $error("watchdog restart pulse wrong");

    sleep_pulse_a: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        cmd_take && cmd_op_in == OP_SLEEP_INSTR |=>
        ##1 (o_sleep_req && status_reg == $past(status_reg, 2)) ##1 !o_sleep_req)
        else $error("sleep request pulse wrong");

    nibble_swap_a: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        done && op_reg == OP_NIBBLE_SWAP |=> rf_a == {$past(rf_a[3:0]), $past(rf_a[7:4])}
        && status_reg == $past(status_reg))
        else $error("nibble swap wrong or flags moved");

    transfer_load_a: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        done && op_reg == OP_TRANSFER_FLAG_TO_BIT |=> rf_a[bit_reg] == status_reg[FLAG_T]
        && (rf_a & ~(8'h01 << bit_reg)) == ($past(rf_a) & ~(8'h01 << bit_reg))
        && status_reg == $past(status_reg))
        else $error("transfer flag load wrong");

    sign_set_a: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        done && op_reg == OP_SIGN_FLAG_SET |=> status_reg == ($past(status_reg) | 8'h10))
        else $error("sign set touched other flags");

endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
    import bsf_pkg::*;
    logic        ref_clk;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        busy;
    logic        sleep_req;
    logic        wdt_restart;
    logic [31:0] rd;
    int          fails = 0;
    int          tests_run = 0;
    int          busy_cnt = 0;
    int          sleep_cnt = 0;
    int          wdt_cnt = 0;
    int          cycles = 0;

    bsf_exec u_dut (.i_ref_clk(ref_clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
        .o_wb_ack(ack), .o_busy(busy), .o_sleep_req(sleep_req), .o_wdt_restart(wdt_restart));

    // 20 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // edge-sampled counts of busy cycles and pulses; a stretched pulse counts twice
    always @(posedge ref_clk) begin
        if (busy === 1'b1) busy_cnt <= busy_cnt + 1;
        if (sleep_req === 1'b1) sleep_cnt <= sleep_cnt + 1;
        if (wdt_restart === 1'b1) wdt_cnt <= wdt_cnt + 1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            $display("Error at %0t: run did not finish", $time);
            results();
        end
    end

    task results;
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // classic single cycle; request held until ack is sampled high
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n = n + 1;
        end while (ack !== 1'b1 && n < 20);
        rd = rdat;
        check({31'h0, ack}, 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, {24'h0, d}, 4'hF);
    endtask

    task rchk(input logic [7:0] a, input logic [7:0] exp);
        wb(1'b0, a, 32'h0, 4'hF);
        check(rd, {24'h0, exp});
    endtask

    function automatic logic [7:0] rfa(input int r);
        return 8'h80 + 8'(4 * r);
    endfunction

    function automatic logic [7:0] ioa(input int i);
        return 8'h40 + 8'(4 * i);
    endfunction

    function automatic logic [31:0] cmdw(input bsf_op_e op, input int b, r, io);
        return {16'h0, io[2:0], r[4:0], b[2:0], op};
    endfunction

    // waits out busy under a bound, then compares the busy length in cycles
    task exec(input bsf_op_e op, input int b, r, io, input logic [1:0] ncyc);
        int n;
        busy_cnt = 0;
        wb(1'b1, ADR_CMD, cmdw(op, b, r, io), 4'h3);
        n = 0;
        while (busy !== 1'b0 && n < 10) begin
            @(posedge ref_clk);
            n = n + 1;
        end
        @(posedge ref_clk);
        check(busy_cnt, {30'h0, ncyc});
    endtask

    // carry out in bit 8, result below; written apart from the design on purpose
    function automatic logic [8:0] shf(input bsf_op_e op, input logic [7:0] v, input logic c);
        case (op)
            OP_LOGICAL_LEFT_SHIFT:  return {v[7], v[6:0], 1'b0};
            OP_LOGICAL_RIGHT_SHIFT: return {v[0], 1'b0, v[7:1]};
            OP_ROTATE_LEFT_CARRY:   return {v[7], v[6:0], c};
            OP_ROTATE_RIGHT_CARRY:  return {v[0], c, v[7:1]};
            default:                return {v[0], v[7], v[7:1]};
        endcase
    endfunction

    task t_reset;
        rchk(ADR_STATUS, STATUS_RESET);
        rchk(ADR_SP, SP_RESET);
        rchk(ADR_STATE, 8'h00);
        rchk(8'h20, 8'h00);
        rchk(rfa(5), 8'h00);
    endtask

    task t_stack;
        wr(rfa(3), 8'hA5);
        wr(ADR_STATUS, 8'h5A);
        exec(OP_STACK_PUSH, 0, 3, 0, CYC_DOUBLE);
        rchk(ADR_SP, 8'h0E);
        rchk(ADR_STATUS, 8'h5A);
        wr(rfa(3), 8'h00);
        exec(OP_STACK_POP, 0, 3, 0, CYC_DOUBLE);
        rchk(rfa(3), 8'hA5);
        rchk(ADR_SP, 8'h0F);
        rchk(ADR_STATUS, 8'h5A);
    endtask

    task t_io;
        wr(ioa(2), 8'h81);
        wr(ADR_STATUS, 8'hA5);
        exec(OP_IO_BIT_SET_INSTR, 5, 0, 2, CYC_DOUBLE);
        rchk(ioa(2), 8'hA1);
        rchk(ioa(1), 8'h00);
        exec(OP_IO_BIT_CLEAR_INSTR, 0, 0, 2, CYC_DOUBLE);
        rchk(ioa(2), 8'hA0);
        rchk(ADR_STATUS, 8'hA5);
    endtask

    // zero results included so the zero flag is driven both ways
    task t_shift;
        logic [7:0] vals [3] = '{8'h80, 8'h01, 8'h5A};
        logic [8:0] e;
        logic [7:0] st;
        bsf_op_e    op;
        for (int k = 0; k < 5; k++) begin
            for (int vi = 0; vi < 3; vi++) begin
                for (int c = 0; c < 2; c++) begin
                    op = bsf_op_e'(OP_LOGICAL_LEFT_SHIFT + k);
                    st = 8'hF6 | 8'(c);
                    e = shf(op, vals[vi], c[0]);
                    wr(rfa(10 + k), vals[vi]);
                    wr(ADR_STATUS, st);
                    exec(op, 0, 10 + k, 0, CYC_SINGLE);
                    rchk(rfa(10 + k), e[7:0]);
                    st[FLAG_C] = e[8];
                    st[FLAG_Z] = (e[7:0] == 8'h00);
                    st[FLAG_N] = e[7];
                    st[FLAG_V] = e[7] ^ e[8];
                    rchk(ADR_STATUS, st);
                end
            end
        end
    endtask

    task t_bits;
        wr(rfa(4), 8'h3C);
        wr(ADR_STATUS, 8'h69);
        exec(OP_NIBBLE_SWAP, 0, 4, 0, CYC_SINGLE);
        rchk(rfa(4), 8'hC3);
        rchk(ADR_STATUS, 8'h69);
        wr(rfa(7), 8'h10);
        wr(ADR_STATUS, 8'hBF);
        exec(OP_BIT_TO_TRANSFER_FLAG, 4, 7, 0, CYC_SINGLE);
        rchk(ADR_STATUS, 8'hFF);
        exec(OP_BIT_TO_TRANSFER_FLAG, 3, 7, 0, CYC_SINGLE);
        rchk(ADR_STATUS, 8'hBF);
        wr(ADR_STATUS, 8'h40);
        exec(OP_TRANSFER_FLAG_TO_BIT, 6, 9, 0, CYC_SINGLE);
        rchk(rfa(9), 8'h40);
        rchk(ADR_STATUS, 8'h40);
    endtask

    // each flag op from the opposite state, so only its own bit may move
    task t_flags;
        int pos [14] = '{FLAG_C, FLAG_C, FLAG_N, FLAG_N, FLAG_Z, FLAG_Z, FLAG_V, FLAG_V,
                         FLAG_S, FLAG_S, FLAG_T, FLAG_T, FLAG_I, FLAG_I};
        logic [7:0] pre;
        for (int k = 0; k < 14; k++) begin
            pre = (k % 2) ? 8'hFF : 8'h00;
            wr(ADR_STATUS, pre);
            exec(bsf_op_e'(OP_CARRY_FLAG_SET + k), 0, 0, 0, CYC_SINGLE);
            rchk(ADR_STATUS, pre ^ (8'h01 << pos[k]));
        end
    endtask

    task t_ctrl;
        wr(ADR_STATUS, 8'h3C);
        sleep_cnt = 0;
        wdt_cnt = 0;
        exec(OP_SLEEP_INSTR, 0, 0, 0, CYC_SINGLE);
        check(sleep_cnt, 1);
        exec(OP_WATCHDOG_RESTART_INSTR, 0, 0, 0, CYC_SINGLE);
        check(wdt_cnt, 1);
        exec(OP_NO_OPERATION, 0, 0, 0, CYC_SINGLE);
        rchk(ADR_STATUS, 8'h3C);
        rchk(ADR_SP, 8'h0F);
        // command write on one lane only must not start the sleep
        wb(1'b1, ADR_CMD, cmdw(OP_SLEEP_INSTR, 0, 0, 0), 4'h1);
        repeat (3) @(posedge ref_clk);
        check(sleep_cnt, 1);
        check(wdt_cnt, 1);
    endtask

    // reset for 8 cycles, then the scenarios in order
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_stack();
        t_io();
        t_shift();
        t_bits();
        t_flags();
        t_ctrl();
        results();
    end
endmodule
